// File: verilog/ssepb_defines.vh
// Notes on behaviour
// RL1 - slave fault needs phase 1 and clock off idle at hold release
// RL2 - idle clock is low for polarity 0, high for 1; checked at release
// RL3 - type A under fault: receive buffer not loaded, receive flag never set
// RL4 - type A under fault: first output bit dropped, rest shifted by one
// RL5 - type B under fault: receives fine, first byte sent twice
// RL6 - external master parks clock at idle before hold release
// RL7 - phase 0 slave never enters the faulty start condition
// RL8 - type A failure seen as transmit flag raised twice, receive flag clear
// RL9 - recovery is setting then clearing the soft reset hold
// RL10 - master resends affected data after slave recovery
// RL11 - four-pin master, enable direction 0: enable pin flags competing master
// RL12 - word written while enable inactive may be sent wrong
// RL13 - enable direction 1: enable pin is an output, data always right
// RL14 - conflict mode: write transmit buffer only while enable active
// RL15 - aborted transfer: software rewrites data, sent when enable returns
// RL16 - serial clock edges ignored while soft reset hold is set
`ifndef SSEPB_DEFINES_VH
`define SSEPB_DEFINES_VH
// register byte offsets
`define SSEPB_OFF_CTRL 8'h00
`define SSEPB_OFF_TXBUF 8'h04
`define SSEPB_OFF_RXBUF 8'h08
`define SSEPB_OFF_STAT 8'h0C
`define SSEPB_OFF_DIV 8'h10
// control word zero fields
`define SSEPB_C_HOLD 0
`define SSEPB_C_CPHA 1
`define SSEPB_C_CPOL 2
`define SSEPB_C_MST 3
`define SSEPB_C_FOUR 4
`define SSEPB_C_STEM 5
`define SSEPB_C_TYPEB 6
`define SSEPB_CTRL_W 7
// status fields
`define SSEPB_S_RXF 0
`define SSEPB_S_TXF 1
`define SSEPB_S_SFLT 2
`define SSEPB_S_FAIL 3
`define SSEPB_S_ABORT 4
`define SSEPB_S_WINACT 5
`define SSEPB_S_BUSY 6
`define SSEPB_S_STEACT 7
// reset values and last bit/half counts
`define SSEPB_CTRL_RST 7'h01
`define SSEPB_DIV_RST 8'h03
`define SSEPB_LAST_BIT 3'h7
`define SSEPB_LAST_HALF 4'hF
`endif

// File: verilog/ssepb_spi_unit.v
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssepb_defines.vh"
module ssepb_spi_unit (
   input  wire        pclk,          // module clock, 40 MHz
   input  wire        presetn,       // async reset, active low
   input  wire        psel,          // apb select
   input  wire        penable,       // apb enable
   input  wire        pwrite,        // apb direction
   input  wire [7:0]  paddr,         // apb byte address
   input  wire [31:0] pwdata,        // apb write data
   output wire [31:0] prdata,        // apb read data
   output wire        pready,        // apb ready
   output wire        pslverr,       // apb error, unmapped
   input  wire        sck_i,         // serial clock pin in
   output wire        sck_o,         // serial clock pin out
   output wire        sck_oe_n,      // serial clock enable, low drives
   input  wire        simo_i,        // master-out data pin in
   output wire        simo_o,        // master-out data pin out
   output wire        simo_oe_n,     // low drives
   input  wire        somi_i,        // slave-out data pin in
   output wire        somi_o,        // slave-out data pin out
   output wire        somi_oe_n,     // low drives
   input  wire        ste_i,         // frame enable pin in, active low
   output wire        ste_o,         // frame enable pin out
   output wire        ste_oe_n       // low drives
);
   reg  [`SSEPB_CTRL_W-1:0] ctrl_ff;
   reg  [7:0]  div_ff;
   reg  [7:0]  divcnt_ff;
   reg  [31:0] prdata_ff;
   reg         pready_ff;
   reg         pslverr_ff;
   reg  [7:0]  txbuf_ff;
   reg         tx_full_ff;
   reg         tx_bad_ff;
   reg  [7:0]  rxbuf_ff;
   reg  [6:0]  rx_sh_ff;
   reg  [7:0]  tx_sh_ff;
   reg  [7:0]  tx_last_ff;
   reg         rx_flag_ff;
   reg         tx_flag_ff;
   reg         sflt_ff;
   reg         first_ff;
   reg         fail_ff;
   reg         abort_ff;
   reg         winact_ff;
   reg  [1:0]  traise_ff;
   reg  [2:0]  cnt_ff;
   reg         loaded_ff;
   reg         sdo_ff;
   reg         run_ff;
   reg  [3:0]  hcnt_ff;
   reg         sck_ff;
   reg         hold_d_ff;
   reg         skip_ff;     // RL5 return to idle after faulty release carries no bit
   reg  [2:0]  sck_s_ff;
   reg  [1:0]  simo_s_ff;
   reg  [1:0]  somi_s_ff;
   reg  [1:0]  ste_s_ff;
   reg         sck_oe_n_ff;
   reg         simo_oe_n_ff;
   reg         somi_oe_n_ff;
   reg         ste_oe_n_ff;
   reg         ste_o_ff;
   reg  [31:0] nxt_prdata;
   reg         nxt_map;

   wire hold   = ctrl_ff[`SSEPB_C_HOLD];
   wire cpha   = ctrl_ff[`SSEPB_C_CPHA];
   wire cpol   = ctrl_ff[`SSEPB_C_CPOL];
   wire mst    = ctrl_ff[`SSEPB_C_MST];
   wire four   = ctrl_ff[`SSEPB_C_FOUR];
   wire stem   = ctrl_ff[`SSEPB_C_STEM];
   wire typeb  = ctrl_ff[`SSEPB_C_TYPEB];
   wire sck_s  = sck_s_ff[1];
   wire ste_s  = ste_s_ff[1];

   // apb completion happens in the single access cycle
   wire acc    = psel & penable & pready_ff;
   wire wr     = acc & pwrite;
   wire rd     = acc & ~pwrite;
   wire wr_ctl = wr & (paddr == `SSEPB_OFF_CTRL);
   wire wr_tx  = wr & (paddr == `SSEPB_OFF_TXBUF) & ~hold;
   wire wr_st  = wr & (paddr == `SSEPB_OFF_STAT);
   wire wr_dv  = wr & (paddr == `SSEPB_OFF_DIV);
   wire rd_rx  = rd & (paddr == `SSEPB_OFF_RXBUF);

   // RL11 enable pin as conflict input
   wire cmode  = mst & four & ~stem;
   wire ste_ok = ~cmode | ~ste_s;
   wire abort  = run_ff & cmode & ste_s;
   // RL16 no edges taken during hold
   wire s_act  = ~hold & ~mst & ~(four & ste_s);
   wire tick   = run_ff & (divcnt_ff == 8'h00);
   // slave edges from synchronised clock, stages 2 and 3
   wire s_edge = s_act & (sck_s ^ sck_s_ff[2]) & ~skip_ff;
   wire lead   = mst ? (tick & (sck_ff == cpol)) : (s_edge & (sck_s != cpol));
   wire trail  = mst ? (tick & (sck_ff != cpol)) : (s_edge & (sck_s == cpol));
   wire sample = cpha ? trail : lead;
   // trailing edge after the last sample carries no bit in phase 0
   wire drive  = cpha ? lead : (trail & (cnt_ff != 3'h0));
   wire bdone  = sample & (cnt_ff == `SSEPB_LAST_BIT);
   wire din    = mst ? somi_s_ff[1] : simo_s_ff[1];
   wire flt_a  = sflt_ff & ~typeb;
   // RL5 first byte repeated on type B
   wire dup    = bdone & sflt_ff & typeb & first_ff;
   wire can_ld = ~hold & tx_full_ff & ~loaded_ff & ~abort
                 & (mst ? (~run_ff & ste_ok) : (cnt_ff == 3'h0));
   wire load   = can_ld & ~(bdone & ~dup);
   // RL4 first bit dropped, RL12 stale word mangled the same way
   wire [7:0] pre = (flt_a | tx_bad_ff) ? {txbuf_ff[6:0], 1'b0} : txbuf_ff;
   wire rx_set = bdone & ~flt_a;
   wire start  = mst & ~hold & loaded_ff & ~run_ff & ste_ok & ~bdone;

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign sck_o     = sck_ff;
   assign sck_oe_n  = sck_oe_n_ff;
   assign simo_o    = sdo_ff;
   assign simo_oe_n = simo_oe_n_ff;
   assign somi_o    = sdo_ff;
   assign somi_oe_n = somi_oe_n_ff;
   assign ste_o     = ste_o_ff;
   assign ste_oe_n  = ste_oe_n_ff;

   // read mux, captured in the setup cycle
   always @* begin
      nxt_map = 1'b1;
      nxt_prdata = 32'h00000000;
      case (paddr)
         `SSEPB_OFF_CTRL:  nxt_prdata[`SSEPB_CTRL_W-1:0] = ctrl_ff;
         `SSEPB_OFF_TXBUF: nxt_prdata[7:0] = txbuf_ff;
         `SSEPB_OFF_RXBUF: nxt_prdata[7:0] = rxbuf_ff;
         `SSEPB_OFF_DIV:   nxt_prdata[7:0] = div_ff;
         `SSEPB_OFF_STAT: begin
            nxt_prdata[`SSEPB_S_RXF]    = rx_flag_ff;
            nxt_prdata[`SSEPB_S_TXF]    = tx_flag_ff;
            nxt_prdata[`SSEPB_S_SFLT]   = sflt_ff;
            nxt_prdata[`SSEPB_S_FAIL]   = fail_ff;
            nxt_prdata[`SSEPB_S_ABORT]  = abort_ff;
            nxt_prdata[`SSEPB_S_WINACT] = winact_ff;
            nxt_prdata[`SSEPB_S_BUSY]   = run_ff | (cnt_ff != 3'h0);
            nxt_prdata[`SSEPB_S_STEACT] = ~ste_s;
         end
         default: nxt_map = 1'b0;
      endcase
   end

   // apb slave: one wait-free access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
         ctrl_ff    <= `SSEPB_CTRL_RST;
         div_ff     <= `SSEPB_DIV_RST;
      end else begin
         pready_ff  <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~nxt_map;
         prdata_ff  <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h00000000;
         if (wr_ctl)
            ctrl_ff <= pwdata[`SSEPB_CTRL_W-1:0];
         if (wr_dv)
            div_ff <= pwdata[7:0];
      end
   end

   // two-flop synchronisers; sck gets a third stage for edges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s_ff  <= 3'h0;
         simo_s_ff <= 2'h0;
         somi_s_ff <= 2'h0;
         ste_s_ff  <= 2'h3;
      end else begin
         sck_s_ff  <= {sck_s_ff[1:0], sck_i};
         simo_s_ff <= {simo_s_ff[0], simo_i};
         somi_s_ff <= {somi_s_ff[0], somi_i};
         ste_s_ff  <= {ste_s_ff[0], ste_i};
      end
   end

   // pin enables and enable output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_oe_n_ff  <= 1'b1;
         simo_oe_n_ff <= 1'b1;
         somi_oe_n_ff <= 1'b1;
         ste_oe_n_ff  <= 1'b1;
         ste_o_ff     <= 1'b1;
      end else begin
         sck_oe_n_ff  <= ~mst;
         simo_oe_n_ff <= ~mst;
         somi_oe_n_ff <= ~s_act;
         // RL13 enable driven out, low while a byte runs
         ste_oe_n_ff  <= ~(mst & four & stem);
         ste_o_ff     <= ~run_ff;
      end
   end

   // master clock generator; divider must allow the 2-flop data delay
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff    <= 1'b0;
         hcnt_ff   <= 4'h0;
         divcnt_ff <= 8'h00;
         sck_ff    <= 1'b0;
      end else if (hold | ~mst | abort) begin
         // RL15 abort parks clock, data must be rewritten
         run_ff    <= 1'b0;
         hcnt_ff   <= 4'h0;
         divcnt_ff <= div_ff;
         sck_ff    <= cpol;
      end else if (start) begin
         run_ff    <= 1'b1;
         hcnt_ff   <= 4'h0;
         divcnt_ff <= div_ff;
      end else if (tick) begin
         sck_ff    <= ~sck_ff;
         hcnt_ff   <= hcnt_ff + 4'h1;
         divcnt_ff <= div_ff;
         if (hcnt_ff == `SSEPB_LAST_HALF)
            run_ff <= 1'b0;
      end else if (run_ff) begin
         divcnt_ff <= divcnt_ff - 8'h01;
      end
   end

   // shift engine, buffers and flags
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_d_ff  <= 1'b1;
         skip_ff    <= 1'b0;
         txbuf_ff   <= 8'h00;
         tx_full_ff <= 1'b0;
         tx_bad_ff  <= 1'b0;
         rxbuf_ff   <= 8'h00;
         rx_sh_ff   <= 7'h00;
         tx_sh_ff   <= 8'h00;
         tx_last_ff <= 8'h00;
         rx_flag_ff <= 1'b0;
         tx_flag_ff <= 1'b1;
         sflt_ff    <= 1'b0;
         first_ff   <= 1'b1;
         fail_ff    <= 1'b0;
         abort_ff   <= 1'b0;
         winact_ff  <= 1'b0;
         traise_ff  <= 2'h0;
         cnt_ff     <= 3'h0;
         loaded_ff  <= 1'b0;
         sdo_ff     <= 1'b0;
      end else begin
         hold_d_ff <= hold;
         if (hold) begin
            // RL9 hold clears failure state for recovery
            tx_full_ff <= 1'b0;
            tx_bad_ff  <= 1'b0;
            rx_flag_ff <= 1'b0;
            tx_flag_ff <= 1'b1;
            sflt_ff    <= 1'b0;
            first_ff   <= 1'b1;
            fail_ff    <= 1'b0;
            traise_ff  <= 2'h0;
            cnt_ff     <= 3'h0;
            loaded_ff  <= 1'b0;
            sdo_ff     <= 1'b0;
         end else begin
            // RL1 RL2 start check at hold release; RL7 phase 0 exempt
            if (hold_d_ff)
               sflt_ff <= ~mst & cpha & (sck_s != cpol);
            skip_ff <= hold_d_ff ? (~mst & cpha & (sck_s != cpol))
                                 : (skip_ff & (sck_s == sck_s_ff[2]));
            if (abort) begin
               cnt_ff    <= 3'h0;
               loaded_ff <= 1'b0;
            end else if (sample) begin
               rx_sh_ff <= {rx_sh_ff[5:0], din};
               cnt_ff   <= cnt_ff + 3'h1;
            end
            if (bdone & ~abort) begin
               loaded_ff <= dup;
               first_ff  <= 1'b0;
            end
            // RL3 type A under fault never fills the buffer
            if (rx_set)
               rxbuf_ff <= {rx_sh_ff, din};
            if (rx_set)
               rx_flag_ff <= 1'b1;
            else if (rd_rx)
               rx_flag_ff <= 1'b0;
            if (dup) begin
               tx_sh_ff <= tx_last_ff;
               if (!cpha)
                  sdo_ff <= tx_last_ff[7];
               if (!cpha)
                  tx_sh_ff <= {tx_last_ff[6:0], 1'b0};
            end else if (load) begin
               loaded_ff  <= 1'b1;
               tx_full_ff <= 1'b0;
               tx_bad_ff  <= 1'b0;
               tx_last_ff <= pre;
               tx_sh_ff   <= cpha ? pre : {pre[6:0], 1'b0};
               if (!cpha)
                  sdo_ff <= pre[7];
            end else if (drive) begin
               sdo_ff   <= tx_sh_ff[7];
               tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            if (load)
               tx_flag_ff <= 1'b1;
            else if (wr_tx)
               tx_flag_ff <= 1'b0;
            if (wr_tx) begin
               txbuf_ff   <= pwdata[7:0];
               tx_full_ff <= 1'b1;
               // RL12 RL14 written while enable inactive
               tx_bad_ff  <= cmode & ste_s;
            end
            // RL8 two transmit raises without a receive
            if (rx_set | rx_flag_ff)
               traise_ff <= 2'h0;
            else if (load & (traise_ff != 2'h2))
               traise_ff <= traise_ff + 2'h1;
            if (load & ~rx_set & ~rx_flag_ff & (traise_ff == 2'h1))
               fail_ff <= 1'b1;
         end
         // sticky conflict flags, set wins over write-one clear
         if (abort)
            abort_ff <= 1'b1;
         else if (wr_st & pwdata[`SSEPB_S_ABORT])
            abort_ff <= 1'b0;
         if (wr_tx & cmode & ste_s)
            winact_ff <= 1'b1;
         else if (wr_st & pwdata[`SSEPB_S_WINACT])
            winact_ff <= 1'b0;
      end
   end
endmodule

// File: bench/ssepb_spi_unit_assertions.sv
`timescale 1ns/1ps
module ssepb_spi_unit_chk (
   input wire        pclk,      // module clock
   input wire        presetn,   // async reset, active low
   input wire        psel,      // apb select
   input wire        penable,   // apb enable
   input wire        pwrite,    // apb direction
   input wire [7:0]  paddr,     // apb address
   input wire [31:0] pwdata,    // apb write data
   input wire [31:0] prdata,    // apb read data
   input wire        pready,    // apb ready
   input wire        pslverr,   // apb error
   input wire        sck_oe_n,  // clock drive, low drives
   input wire        somi_oe_n, // slave data drive
   input wire        ste_oe_n   // enable pin drive
);
   reg [6:0] ctrl_ff;
   // shadow of the control word, follows completed writes only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_ff <= 7'h01;
      else if (psel && penable && pready && pwrite && paddr == 8'h00)
         ctrl_ff <= pwdata[6:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy_first; psel && penable && !$past(penable) |-> pready; endproperty
   a_rdy_first: assert property (p_rdy_first) else $error("no ready in access");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_rdy_access; pready |-> psel && penable; endproperty
   a_rdy_access: assert property (p_rdy_access) else $error("ready outside access");
   property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10); endproperty
   a_err: assert property (p_err) else $error("error flag wrong");
   property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
   property p_rd_ctrl; pready && !pwrite && paddr == 8'h00 |-> prdata == {25'h0, ctrl_ff}; endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
   property p_hold_quiet; ctrl_ff[0] && $past(ctrl_ff[0]) |-> somi_oe_n; endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("slave out while held");
   property p_ste_out; !ste_oe_n && $stable(ctrl_ff) |-> ctrl_ff[5:3] == 3'h7; endproperty
   a_ste_out: assert property (p_ste_out) else $error("enable pin driven wrongly");
   property p_sck_drive; !sck_oe_n && $stable(ctrl_ff) |-> ctrl_ff[3]; endproperty
   a_sck_drive: assert property (p_sck_drive) else $error("clock driven as slave");
endmodule
bind ssepb_spi_unit ssepb_spi_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sck_oe_n(sck_oe_n), .somi_oe_n(somi_oe_n),
   .ste_oe_n(ste_oe_n));

// File: bench/ssepb_ext_master.sv
`timescale 1ns/1ps
module ssepb_ext_master (
   output logic sck,   // serial clock to slave
   output logic simo,  // data to slave
   output logic ste_n, // enable, active low
   input  wire  somi   // data from slave
);
   initial begin
      sck = 1'h0;
      simo = 1'h0;
      ste_n = 1'h1;
   end
   // clock parked at the given level, which the fault tests set off idle
   task park(input logic lvl);
      sck = lvl;
   endtask
   task set_ste(input logic v);
      ste_n = v;
   endtask
   // one byte msb first, 200 ns period; clock stands still between frames
   task xfer(input logic [7:0] tx, input logic cpol, input logic cpha, output logic [7:0] rx);
      integer i;
      #3;
      ste_n = 1'h0;
      for (i = 7; i >= 0; i--) begin
         if (!cpha) simo = tx[i];
         #100 sck = ~cpol;
         if (cpha) simo = tx[i];
         else rx = {rx[6:0], somi};
         #100 sck = cpol;
         if (cpha) rx = {rx[6:0], somi};
      end
      #100 ste_n = 1'h1;
      simo = ~simo; // released line shows no stale bit
   endtask
endmodule

// File: bench/ssepb_spi_unit_tb_top.sv
`timescale 1ns/1ps
`include "ssepb_defines.vh"
module ssepb_spi_unit_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, somi_last, e;
   logic [7:0]  paddr, b, b2;
   logic [31:0] pwdata, r;
   wire  [31:0] prdata;
   wire         pready, pslverr, sck_o, sck_oe_n, simo_o, simo_oe_n, somi_o, somi_oe_n;
   wire         ste_o, ste_oe_n, m_sck, m_simo, m_ste_n;
   int          miscompares, tests_run;
   // pin levels from both parties; released slave line shows the inverse
   wire sck_w = sck_oe_n ? m_sck : sck_o;
   wire simo_w = simo_oe_n ? m_simo : simo_o;
   wire somi_w = somi_oe_n ? ~somi_last : somi_o;
   wire ste_w = ste_oe_n ? m_ste_n : ste_o;
   always @(posedge pclk) if (!somi_oe_n) somi_last <= somi_o;
   ssepb_spi_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .simo_i(simo_w),
      .simo_o(simo_o), .simo_oe_n(simo_oe_n), .somi_i(simo_o), .somi_o(somi_o),
      .somi_oe_n(somi_oe_n), .ste_i(ste_w), .ste_o(ste_o), .ste_oe_n(ste_oe_n));
   ssepb_ext_master m (.sck(m_sck), .simo(m_simo), .ste_n(m_ste_n), .somi(somi_w));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // apb transfer held until ready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task cap(output logic [7:0] v);
      repeat (8) begin
         @(posedge sck_o);
         v = {v[6:0], simo_o};
      end
   endtask
   task t_regs;
      apb(0, `SSEPB_OFF_CTRL, 0); chk(r, 32'h1);
      apb(0, `SSEPB_OFF_DIV, 0); chk(r, 32'h3);
      apb(0, 8'h14, 0); chk(e, 1); chk(r, 0);
      $display("test regs done");
   endtask
   task t_slave;
      m.park(0); m.xfer(8'h77, 0, 0, b);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[0], 0);
      apb(1, `SSEPB_OFF_CTRL, 0); apb(1, `SSEPB_OFF_TXBUF, 8'hA5);
      m.xfer(8'h3C, 0, 0, b); chk(b, 8'hA5);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[0], 1);
      apb(0, `SSEPB_OFF_RXBUF, 0); chk(r, 32'h3C);
      apb(1, `SSEPB_OFF_CTRL, 8'h07); m.park(1); apb(1, `SSEPB_OFF_CTRL, 8'h06);
      apb(1, `SSEPB_OFF_TXBUF, 8'h4B); m.xfer(8'hD2, 1, 1, b); chk(b, 8'h4B);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[2], 0); chk(r[0], 1);
      apb(0, `SSEPB_OFF_RXBUF, 0); chk(r, 32'hD2);
      $display("test slave done");
   endtask
   task t_fault_a;
      apb(1, `SSEPB_OFF_CTRL, 8'h03); m.park(1); apb(1, `SSEPB_OFF_CTRL, 8'h02); m.park(0);
      apb(1, `SSEPB_OFF_TXBUF, 8'hB7); m.xfer(8'h5A, 0, 1, b);
      chk(b, 8'h6E);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[2], 1); chk(r[0], 0);
      apb(1, `SSEPB_OFF_TXBUF, 8'hB7); m.xfer(8'h5A, 0, 1, b);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[3], 1); chk(r[0], 0);
      // reset the slave, idle clock, master resends
      apb(1, `SSEPB_OFF_CTRL, 8'h03); apb(1, `SSEPB_OFF_CTRL, 8'h02);
      apb(1, `SSEPB_OFF_TXBUF, 8'hE1); m.xfer(8'h5A, 0, 1, b); chk(b, 8'hE1);
      apb(0, `SSEPB_OFF_RXBUF, 0); chk(r, 32'h5A);
      $display("test fault_a done");
   endtask
   task t_fault_b;
      apb(1, `SSEPB_OFF_CTRL, 8'h43); m.park(1); apb(1, `SSEPB_OFF_CTRL, 8'h42); m.park(0);
      apb(1, `SSEPB_OFF_TXBUF, 8'h81); m.xfer(8'h11, 0, 1, b);
      apb(1, `SSEPB_OFF_TXBUF, 8'h42); m.xfer(8'h22, 0, 1, b2);
      chk(b, 8'h81);
      chk(b2, 8'h81);
      apb(0, `SSEPB_OFF_RXBUF, 0); chk(r, 32'h22);
      $display("test fault_b done");
   endtask
   task t_master;
      apb(1, `SSEPB_OFF_CTRL, 8'h39); apb(1, `SSEPB_OFF_CTRL, 8'h38);
      fork apb(1, `SSEPB_OFF_TXBUF, 8'hC3); cap(b); join
      chk(b, 8'hC3);
      apb(0, `SSEPB_OFF_RXBUF, 0); chk(r, 32'hC3);
      apb(1, `SSEPB_OFF_CTRL, 8'h19); m.set_ste(1); apb(1, `SSEPB_OFF_CTRL, 8'h18);
      apb(1, `SSEPB_OFF_TXBUF, 8'h96); apb(0, `SSEPB_OFF_STAT, 0); chk(r[5], 1);
      m.set_ste(0); cap(b); chk(b[7:1], 7'h16);
      apb(1, `SSEPB_OFF_STAT, 8'h30);
      fork apb(1, `SSEPB_OFF_TXBUF, 8'h5A); begin repeat (3) @(posedge sck_o); m.set_ste(1); end join
      repeat (80) @(posedge pclk);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r[4], 1); chk(sck_o, 0);
      apb(1, `SSEPB_OFF_STAT, 8'h30); m.set_ste(0);
      fork apb(1, `SSEPB_OFF_TXBUF, 8'h5A); cap(b); join
      chk(b, 8'h5A);
      $display("test master done");
   endtask
   // mid-run reset: outputs quiet, hold set again, flags back to rest
   task t_reset;
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(pready, 0); chk(sck_oe_n, 1); chk(ste_o, 1);
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(0, `SSEPB_OFF_CTRL, 0); chk(r, 32'h1);
      apb(0, `SSEPB_OFF_STAT, 0); chk(r, 32'h2);
      $display("test reset done");
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   // hang guard, about twenty times the expected run
   initial begin
      #500000;
      miscompares++;
      stop_test;
   end
   initial begin
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0;
      pwdata = 32'h0; somi_last = 1'h0; miscompares = 0; tests_run = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_regs;
      t_slave;
      t_fault_a;
      t_fault_b;
      t_reset;
      t_master;
      stop_test;
   end
endmodule
